// *** common/dtp_pkg.sv ***
// package: register map, fields and constants of the dual timer block
package dtp_pkg;
	// register byte offsets (aligned words)
	localparam logic [7:0] ADDR_A_CMP = 8'h00;
	localparam logic [7:0] ADDR_B_CMP = 8'h04;
	localparam logic [7:0] ADDR_B_HCMP = 8'h08;
	localparam logic [7:0] ADDR_A_CNT = 8'h0C;
	localparam logic [7:0] ADDR_B_CNT = 8'h10;
	localparam logic [7:0] ADDR_A_MODE = 8'h14;
	localparam logic [7:0] ADDR_B_MODE = 8'h18;
	localparam logic [7:0] ADDR_SRC = 8'h1C;
	// mode control fields
	localparam int EN_BIT = 7;
	localparam int CLK_LSB = 3;
	localparam int MD_LSB = 1;
	localparam int OE_BIT = 0;
	// operation mode codes: {a_md[1:0], b_md[1:0]}
	localparam logic [3:0] MD_DISCRETE = 4'h0;
	localparam logic [3:0] MD_CASCADE = 4'h5;
	localparam logic [3:0] MD_CARRIER = 4'h3;
	localparam logic [3:0] MD_PWM = 4'h2;
	// timer a clock selects (3-bit field plus source extension bit)
	localparam logic [2:0] ACLK_DIV6 = 3'h0;
	localparam logic [2:0] ACLK_DIV8 = 3'h1;
	localparam logic [2:0] ACLK_DIV4 = 3'h2;
	localparam logic [2:0] ACLK_DIV10 = 3'h3;
	localparam logic [2:0] ACLK_BMATCH = 3'h4;
	localparam logic [2:0] ACLK_CARRIER = 3'h5;
	localparam int PRESC_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	typedef enum logic [2:0] {
		DTP_MDISC = 3'b001,
		DTP_MCASC = 3'b010,
		DTP_MCARPWM = 3'b100
	} dtp_mode_e;
endpackage

// *** logic/dtp_timer.sv ***
// file: dual 8-bit timer with cascade, carrier and pwm, axi4-lite slave
//
// Operation
// - discrete: two independent 8-bit interval timers
// - cascade: one 16-bit interval timer
// - carrier: b carrier gated by a periods
// - pwm: b toggles output by two compares
// - a compare match raises timer a irq outside cascade
// - b compare match raises timer b irq in discrete; high compare match in carrier/pwm
// - cascade: b irq on joint match only
// - carrier/pwm: b compare sets low width
// - carrier/pwm: high compare sets high width
// - counters reset to zero; byte access
// - discrete a clears: enable, match, overflow
// - discrete b clears: enable, match, overflow
// - cascade both clear together on joint events
// - carrier: a match clear, b both-width clear
// - pwm b clears: enable, matches, overflow
// - cascade: b enable drives both counters
// - cascade: a clocked by b overflow
`timescale 1ns/10ps
module dtp_timer #(
	parameter int B_DIV = 1 // timer b count clock divide, system cycles
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic timer_a_irq,
	output logic timer_b_irq,
	output logic timer_b_output_pin
);
	initial begin
		if (B_DIV < 1 || B_DIV > 255) begin
			$error("dtp_timer: B_DIV out of range");
		end
	end

	// local names for package items, nothing is imported
	localparam int PRESC_W = dtp_pkg::PRESC_W;
	localparam dtp_pkg::dtp_mode_e DTP_MDISC = dtp_pkg::DTP_MDISC;
	localparam dtp_pkg::dtp_mode_e DTP_MCASC = dtp_pkg::DTP_MCASC;
	localparam dtp_pkg::dtp_mode_e DTP_MCARPWM = dtp_pkg::DTP_MCARPWM;

	// software registers
	logic [7:0] timer_a_compare; // undefined at reset in silicon; held 0
	logic [7:0] timer_b_compare;
	logic [7:0] timer_b_high_width_compare;
	logic [7:0] timer_a_mode_control;
	logic [7:0] timer_b_mode_control;
	logic [7:0] timer_a_source_clock_control;
	logic [7:0] timer_a_counter;
	logic [7:0] timer_b_counter;
	logic out_lvl; // timer b output level before enable gate
	logic gate_lvl; // carrier gate from timer a
	logic [PRESC_W-1:0] presc; // free prescaler for timer a
	logic [7:0] bdiv; // timer b count clock divider

	// axi write channel latches
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	// decoded control
	logic [3:0] mode_code;
	dtp_pkg::dtp_mode_e mode;
	logic b_en;
	logic a_en;
	logic b_tick;
	logic a_tick;
	logic a_match;
	logic b_match;
	logic bh_match;
	logic [7:0] b_cmp_now;
	logic b_clr;
	logic a_clr;
	logic a_ovf;
	logic b_ovf;
	logic b_pulse; // timer b match output, feeds timer a on the b-match and carrier clock selects

	// one prescaler bit falling edge selector
	function automatic logic tap_edge(input logic [PRESC_W-1:0] p,
		input int n);
		logic all_set;
		// variable tap width, so scan bit by bit
		all_set = 1'b1;
		for (int i = 0; i < PRESC_W; i++) begin
			if (i < n && !p[i]) begin
				all_set = 1'b0;
			end
		end
		tap_edge = all_set;
	endfunction

	assign mode_code = {timer_a_mode_control[dtp_pkg::MD_LSB+:2],
		timer_b_mode_control[dtp_pkg::MD_LSB+:2]};

	// mode decode; prohibited codes fall back to discrete
	always_comb begin
		if (mode_code == dtp_pkg::MD_CASCADE) begin
			mode = DTP_MCASC;
		end else if (mode_code == dtp_pkg::MD_CARRIER ||
			mode_code == dtp_pkg::MD_PWM) begin
			mode = DTP_MCARPWM;
		end else begin
			mode = DTP_MDISC;
		end
	end

	// enables: in cascade only b's bit counts
	assign b_en = timer_b_mode_control[dtp_pkg::EN_BIT];
	assign a_en = (mode == DTP_MCASC) ? b_en
		: timer_a_mode_control[dtp_pkg::EN_BIT];

	// timer b count clock
	assign b_tick = b_en && (bdiv == 8'(B_DIV - 1));

	// compare against low or high width by output phase
	assign b_cmp_now = (mode == DTP_MCARPWM && out_lvl)
		? timer_b_high_width_compare : timer_b_compare;
	assign b_match = (timer_b_counter == timer_b_compare);
	assign bh_match = (timer_b_counter == b_cmp_now) && out_lvl;
	assign a_match = (timer_a_counter == timer_a_compare);
	assign a_ovf = (timer_a_counter == 8'hFF);
	assign b_ovf = (timer_b_counter == 8'hFF);
	assign b_pulse = b_tick && (timer_b_counter == b_cmp_now);

	// timer a count clock select
	always_comb begin
		a_tick = 1'b0;
		if (mode == DTP_MCASC) begin
			a_tick = b_tick && b_ovf;
		end else begin
			case (timer_a_mode_control[dtp_pkg::CLK_LSB+:3])
				dtp_pkg::ACLK_DIV6: a_tick = tap_edge(presc, 6);
				dtp_pkg::ACLK_DIV8: a_tick = tap_edge(presc, 8);
				dtp_pkg::ACLK_DIV4: a_tick = tap_edge(presc, 4);
				dtp_pkg::ACLK_DIV10: a_tick = timer_a_source_clock_control[0]
					? tap_edge(presc, 12) : tap_edge(presc, 10);
				dtp_pkg::ACLK_BMATCH: a_tick = b_pulse;
				dtp_pkg::ACLK_CARRIER: a_tick = b_pulse && out_lvl;
				default: a_tick = 1'b0;
			endcase
		end
		a_tick = a_tick && a_en;
	end

	// clear conditions per mode
	always_comb begin
		a_clr = 1'b0;
		b_clr = 1'b0;
		case (mode)
			DTP_MDISC: begin
				a_clr = a_match || a_ovf;
				b_clr = b_match || b_ovf;
			end
			DTP_MCASC: begin
				// joint match or joint overflow wraps all 16 bits
				a_clr = (a_match && b_match) || (a_ovf && b_ovf);
				b_clr = a_clr;
			end
			DTP_MCARPWM: begin
				a_clr = a_match;
				b_clr = (timer_b_counter == b_cmp_now) ||
					(mode_code == dtp_pkg::MD_PWM && b_ovf);
			end
			default: begin
				a_clr = 1'b0;
				b_clr = 1'b0;
			end
		endcase
	end

	// free prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= '0;
		end else begin
			presc <= presc + 1'b1;
		end
	end

	// timer b clock divider, held while stopped
	always_ff @(posedge aclk) begin
		if (!aresetn || !b_en || bdiv == 8'(B_DIV - 1)) begin
			bdiv <= 8'h00;
		end else begin
			bdiv <= bdiv + 8'h01;
		end
	end

	// timer b counter
	always_ff @(posedge aclk) begin
		if (!aresetn || !b_en) begin
			timer_b_counter <= dtp_pkg::CNT_RESET;
		end else if (b_tick) begin
			if (mode == DTP_MCASC) begin
				timer_b_counter <= b_clr ? dtp_pkg::CNT_RESET
					: timer_b_counter + 8'h01;
			end else begin
				timer_b_counter <= b_clr ? dtp_pkg::CNT_RESET
					: timer_b_counter + 8'h01;
			end
		end
	end

	// timer a counter; in cascade it is the high byte
	always_ff @(posedge aclk) begin
		if (!aresetn || !a_en) begin
			timer_a_counter <= dtp_pkg::CNT_RESET;
		end else if (mode == DTP_MCASC && b_tick && b_clr) begin
			timer_a_counter <= dtp_pkg::CNT_RESET;
		end else if (a_tick) begin
			timer_a_counter <= (a_clr && mode != DTP_MCASC)
				? dtp_pkg::CNT_RESET : timer_a_counter + 8'h01;
		end
	end

	// timer b output: toggles on each width match in carrier/pwm, on each b clear otherwise
	always_ff @(posedge aclk) begin
		if (!aresetn || !b_en) begin
			out_lvl <= 1'b0;
		end else if (b_tick && mode == DTP_MCARPWM &&
			timer_b_counter == b_cmp_now) begin
			out_lvl <= !out_lvl;
		end else if (b_tick && mode != DTP_MCARPWM && b_clr) begin
			out_lvl <= !out_lvl; // square wave
		end
	end

	// carrier gate flips every timer a period
	always_ff @(posedge aclk) begin
		if (!aresetn || !a_en) begin
			gate_lvl <= 1'b0;
		end else if (a_tick && a_match) begin
			gate_lvl <= !gate_lvl;
		end
	end

	// output pin register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_b_output_pin <= 1'b0;
		end else if (!timer_b_mode_control[dtp_pkg::OE_BIT]) begin
			timer_b_output_pin <= 1'b0;
		end else if (mode_code == dtp_pkg::MD_CARRIER) begin
			timer_b_output_pin <= out_lvl && gate_lvl;
		end else begin
			timer_b_output_pin <= out_lvl;
		end
	end

	// interrupt pulses, one aclk cycle wide
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_a_irq <= 1'b0;
			timer_b_irq <= 1'b0;
		end else begin
			timer_a_irq <= a_tick && a_match &&
				mode != DTP_MCASC;
			if (mode == DTP_MCASC) begin
				timer_b_irq <= b_tick && a_match && b_match;
			end else if (mode == DTP_MCARPWM) begin
				timer_b_irq <= b_tick && bh_match;
			end else begin
				timer_b_irq <= b_tick && b_match;
			end
		end
	end

	// axi write address/data capture, either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dtp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] > dtp_pkg::ADDR_SRC[7:2] ||
					aw_addr == dtp_pkg::ADDR_A_CNT ||
					aw_addr == dtp_pkg::ADDR_B_CNT)
					? dtp_pkg::RESP_SLVERR : dtp_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes, low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_a_compare <= 8'h00;
			timer_b_compare <= 8'h00;
			timer_b_high_width_compare <= 8'h00;
			timer_a_mode_control <= dtp_pkg::MODE_RESET;
			timer_b_mode_control <= dtp_pkg::MODE_RESET;
			timer_a_source_clock_control <= dtp_pkg::MODE_RESET;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr[7:2] == dtp_pkg::ADDR_A_CMP[7:2]) begin
				timer_a_compare <= w_data[7:0];
			end else if (aw_addr[7:2] == dtp_pkg::ADDR_B_CMP[7:2]) begin
				timer_b_compare <= w_data[7:0];
			end else if (aw_addr[7:2] == dtp_pkg::ADDR_B_HCMP[7:2]) begin
				timer_b_high_width_compare <= w_data[7:0];
			end else if (aw_addr[7:2] == dtp_pkg::ADDR_A_MODE[7:2]) begin
				timer_a_mode_control <= w_data[7:0] & 8'hBE;
			end else if (aw_addr[7:2] == dtp_pkg::ADDR_B_MODE[7:2]) begin
				timer_b_mode_control <= w_data[7:0] & 8'hBF;
			end else if (aw_addr[7:2] == dtp_pkg::ADDR_SRC[7:2]) begin
				timer_a_source_clock_control <= w_data[7:0] & 8'h01;
			end
		end
	end

	// read channel, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= dtp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= dtp_pkg::RESP_OKAY;
			if (s_axi_araddr[7:2] == dtp_pkg::ADDR_A_CMP[7:2]) begin
				s_axi_rdata <= {24'h0, timer_a_compare};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_B_CMP[7:2]) begin
				s_axi_rdata <= {24'h0, timer_b_compare};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_B_HCMP[7:2]) begin
				s_axi_rdata <= {24'h0, timer_b_high_width_compare};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_A_CNT[7:2]) begin
				s_axi_rdata <= {24'h0, timer_a_counter};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_B_CNT[7:2]) begin
				s_axi_rdata <= {24'h0, timer_b_counter};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_A_MODE[7:2]) begin
				s_axi_rdata <= {24'h0, timer_a_mode_control};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_B_MODE[7:2]) begin
				s_axi_rdata <= {24'h0, timer_b_mode_control};
			end else if (s_axi_araddr[7:2] == dtp_pkg::ADDR_SRC[7:2]) begin
				s_axi_rdata <= {24'h0, timer_a_source_clock_control};
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= dtp_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // dtp_timer

// *** verification/dtp_timer_properties.sv ***
// checker: bus handshake and irq pulse properties of the dual timer
`timescale 1ns/10ps
module dtp_timer_properties #(
	parameter int B_DIV = 1 // mirrors the timer b divider
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_a_irq,
	input wire logic timer_b_irq,
	input wire logic timer_b_output_pin
);
	// one domain, so clock and reset are given once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// no irq or write response may be pending straight out of reset
	reset_quiet_a: assert property (
		$rose(aresetn) |-> !timer_a_irq && !timer_b_irq && !s_axi_bvalid)
		else $error("output busy after reset");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write not answered");
	write_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	// a second write must wait for the response to go
	write_block_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	read_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// registers are one byte wide
	read_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	read_busy_a: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	irq_a_pulse_a: assert property (
		timer_a_irq |=> !timer_a_irq) else $error("timer a irq too long");
	irq_b_pulse_a: assert property (
		$rose(timer_b_irq) |=> $fell(timer_b_irq))
		else $error("timer b irq too long");
endmodule // dtp_timer_properties

bind dtp_timer dtp_timer_properties #(.B_DIV(B_DIV)) dtp_timer_properties_inst (.*);

// *** verification/tb_dtp_timer.sv ***
// testbench: registers, discrete, cascade, pwm and carrier runs of the dual timer
`timescale 1ns/10ps
module tb_dtp_timer;
	localparam int BD = 2; // slow b clock keeps irq pulses apart
	logic aclk = 1'b0;
	logic aresetn = 1'b0; // held low for three edges
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h1; // only the low byte is stored
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic timer_a_irq, timer_b_irq, timer_b_output_pin;
	int err_total = 0;
	int samples_checked = 0;
	dtp_timer #(.B_DIV(BD)) dtp_timer_inst (.*);
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write: offer address and data together, drop each once taken
	task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
		bit ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta |= s_axi_awready;
			tw |= s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", er, s_axi_bresp);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	// read: hold the address until taken, rready until data seen
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// cycles up to the next irq, pin-high cycles, any timer a irq seen
	task automatic wirq(input bit b, output int c, hi, output bit sa);
		c = 0;
		hi = 0;
		sa = 1'b0;
		do begin
			@(negedge aclk);
			c++;
			hi += timer_b_output_pin;
			sa |= timer_a_irq;
		end while ((b ? timer_b_irq : timer_a_irq) !== 1'b1 && c < 3000);
	endtask
	// reset values, read-back, read-only and unmapped places
	task automatic t_regs();
		rd(dtp_pkg::ADDR_A_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_B_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_CMP, 8'hA5, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_HCMP, 8'h5A, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_A_CMP, 32'hA5, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_B_HCMP, 32'h5A, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_CNT, 8'h33, dtp_pkg::RESP_SLVERR);
		rd(dtp_pkg::ADDR_A_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		rd(8'h20, 32'h0, dtp_pkg::RESP_SLVERR);
		$display("test regs done");
	endtask
	// timer a alone: compare 2 on the /16 tap gives 48 cycles
	task automatic t_disc_a();
		int c, h;
		bit s;
		wr(dtp_pkg::ADDR_A_CMP, 8'h02, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_MODE, 8'h90, dtp_pkg::RESP_OKAY);
		wirq(1'b0, c, h, s);
		wirq(1'b0, c, h, s);
		chk("a period", 32'h30, c);
		wr(dtp_pkg::ADDR_A_MODE, 8'h10, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_A_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		$display("test discrete a done");
	endtask
	// timer b alone with square wave out
	task automatic t_disc_b();
		int c, h;
		bit s;
		logic p;
		wr(dtp_pkg::ADDR_B_CMP, 8'h04, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_MODE, 8'h81, dtp_pkg::RESP_OKAY);
		wirq(1'b1, c, h, s);
		p = timer_b_output_pin;
		wirq(1'b1, c, h, s);
		chk("b period", 32'hA, c);
		chk("b square", {31'h0, ~p}, {31'h0, timer_b_output_pin});
		wr(dtp_pkg::ADDR_B_MODE, 8'h01, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_B_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		$display("test discrete b done");
	endtask
	// 16-bit compare 0x0101 with timer a enable left clear
	task automatic t_casc();
		int c, h;
		bit s;
		wr(dtp_pkg::ADDR_A_CMP, 8'h01, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_CMP, 8'h01, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_MODE, 8'h02, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_MODE, 8'h83, dtp_pkg::RESP_OKAY);
		wirq(1'b1, c, h, s);
		wirq(1'b1, c, h, s);
		chk("cascade period", 32'h204, c);
		chk("cascade a irq", 32'h0, s);
		wr(dtp_pkg::ADDR_B_MODE, 8'h02, dtp_pkg::RESP_OKAY);
		rd(dtp_pkg::ADDR_A_CNT, 32'h0, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_MODE, 8'h00, dtp_pkg::RESP_OKAY);
		$display("test cascade done");
	endtask
	// low width 3 ticks, high width 4 ticks, b tick is two cycles
	task automatic t_pwm();
		int c, h;
		bit s;
		wr(dtp_pkg::ADDR_B_CMP, 8'h02, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_HCMP, 8'h03, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_MODE, 8'h85, dtp_pkg::RESP_OKAY);
		wirq(1'b1, c, h, s);
		wirq(1'b1, c, h, s);
		chk("pwm period", 32'hE, c);
		chk("pwm high", 32'h8, h);
		wr(dtp_pkg::ADDR_B_MODE, 8'h05, dtp_pkg::RESP_OKAY);
		$display("test pwm done");
	endtask
	// carrier: b flips every tick, gate flips each 16-cycle a period
	task automatic t_carr();
		int c, h1, h2;
		bit s;
		wr(dtp_pkg::ADDR_A_CMP, 8'h00, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_CMP, 8'h00, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_HCMP, 8'h00, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_MODE, 8'h90, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_B_MODE, 8'h87, dtp_pkg::RESP_OKAY);
		wirq(1'b0, c, h1, s);
		wirq(1'b0, c, h1, s);
		wirq(1'b0, c, h2, s);
		chk("carrier period", 32'h10, c);
		chk("carrier high", 32'h8, h1 + h2);
		chk("carrier gated", 32'h0, h1 * h2);
		wr(dtp_pkg::ADDR_B_MODE, 8'h07, dtp_pkg::RESP_OKAY);
		wr(dtp_pkg::ADDR_A_MODE, 8'h10, dtp_pkg::RESP_OKAY);
		$display("test carrier done");
	endtask
	// counts and verdict, the one way out
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog well past the fewer than two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_disc_a();
		t_disc_b();
		t_casc();
		t_pwm();
		t_carr();
		end_sim();
	end
endmodule // tb_dtp_timer
